// >>> rtl/aux_pin_pkg.sv
// Constants for the auxiliary pin function control block.
// Assumes an 8-bit register port on the system clock.
package aux_pin_pkg;

    // ****************************************
    // Register addresses and reset value
    // ****************************************
    localparam logic [7:0] ADDR_CLOCK_OUT_PIN_AND_INT_POLARITY = 8'hA1;
    localparam logic [7:0] ADDR_KEYPAD_SPI_UART_PIN_ROUTING     = 8'hA2;
    localparam logic [7:0] ADDR_INTERRUPT_INPUT_TIMER_CLOCK     = 8'hA3;
    localparam logic [7:0] ADDR_BUS_DETECT_BEEPER_PIN_ROUTING   = 8'hA4;
    localparam logic [7:0] REG_RESET                            = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int B0_CLKOUT_HI = 7;
    localparam int B0_CLKOUT_LO = 6;
    localparam int B0_FAST_DRV  = 5;
    localparam int B0_P4FN_HI   = 3;
    localparam int B0_P4FN_LO   = 2;
    localparam int B0_IRQ1_POL  = 1;
    localparam int B0_IRQ0_POL  = 0;
    localparam int B1_KEY_HI    = 7;
    localparam int B1_KEY_LO    = 6;
    localparam int B1_SPI       = 5;
    localparam int B1_UART1     = 4;
    localparam int B1_SER1_IN   = 3;
    localparam int B1_TW0       = 2;
    localparam int B1_CAPTURE   = 1;
    localparam int B1_DATA_POINTER      = 0;
    localparam int B2_IRQ3_HI   = 7;
    localparam int B2_IRQ3_LO   = 6;
    localparam int B2_IRQ2_HI   = 5;
    localparam int B2_IRQ2_LO   = 4;
    localparam int B2_T1_FAST   = 3;
    localparam int B2_T0_FAST   = 2;
    localparam int B2_T1_CKOE   = 1;
    localparam int B2_T0_CKOE   = 0;
    localparam int B3_START     = 7;
    localparam int B3_STOP      = 6;
    localparam int B3_BEEP_HI   = 5;
    localparam int B3_BEEP_LO   = 4;
    localparam int B3_SER0_IN   = 2;
    localparam int B3_ECI       = 1;
    localparam int B3_TW1       = 0;

    // ****************************************
    // Codes and divider counts
    // ****************************************
    typedef enum logic [1:0] {
        CLK_OFF  = 2'h0,
        CLK_DIV1 = 2'h1,
        CLK_DIV2 = 2'h2,
        CLK_DIV4 = 2'h3
    } clock_out_sel_t;

    localparam logic [1:0] BEEP_OFF    = 2'h0;
    localparam logic [1:0] BEEP_DIV64  = 2'h1;
    localparam logic [1:0] BEEP_DIV32  = 2'h2;
    localparam logic [4:0] BEEP_HALF64 = 5'h1F;
    localparam logic [4:0] BEEP_HALF32 = 5'h0F;
    localparam logic [4:0] BEEP_HALF16 = 5'h07;
    localparam logic [3:0] PRESCALE_LAST = 4'hB;

endpackage : aux_pin_pkg

// >>> rtl/aux_pin_function_control.sv
// Auxiliary pin function control: four routing registers, clock and
// beeper outputs, timer prescale ticks and bus start/stop flags.
// Assumes clk is the master clock and the register port is on clk.
//
// Summary of operation
// - Pin 6.0 clock output acts only while an internal RC clocks the system.
// - Clock field 00 leaves general I/O; 01/10/11 give master clock /1,/2,/4.
// - Fast-drive bit selects stronger drive on pin 6.0.
// - Port 4 pair field picks port, UART0, timer 0/1, or timer 2 functions.
// - Polarity bits switch interrupts 0 and 1 to high or rising trigger.
// - Keypad high nibble on port 2 when clear, port 1 when set.
// - Keypad low nibble on port 2 when clear, port 3 when set.
// - SPI pins on port 1 when clear, ports 2 and 4 when set.
// - Secondary UART moves to port 3 only while capture relocation is off.
// - Secondary serial-in from pin 1.0 when clear, pin 3.5 when set.
// - Two-wire 0 moves to port 6 only while clock field is 00.
// - Capture outputs on port 2 when clear, port 3 when set.
// - Data pointer select picks pointer 0 or pointer 1.
// - Interrupt 3 and 2 input select fields pick one of four pins.
// - Timer prescale bit picks system clock /12 or undivided clock.
// - Clock-out enable bits drive timer clock outputs to their pins.
// - Start condition sets start flag; writing zero clears it.
// - Stop condition sets stop flag; writing zero clears it.
// - Beeper field outputs low-frequency RC /64, /32 or /16 on pin 4.4.
// - Primary serial-in from pin 3.2 when clear, pin 1.6 when set.
// - Counter external input from pin 2.1 when clear, pin 3.2 when set.
// - Two-wire 1 on port 1 when clear, port 3 when set.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

module aux_pin_function_control (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       sys_clock_internal_rc,
    input  wire logic       stw_scl_in,
    input  wire logic       stw_sda_in,
    input  wire logic       low_freq_rc_osc,
    output logic            pin60_clock_out,
    output logic            pin60_clock_pass,
    output logic            pin60_clock_active,
    output logic            pin60_fast_drive,
    output logic      [1:0] port4_pair_function_select,
    output logic            ext_irq1_high_polarity,
    output logic            ext_irq0_high_polarity,
    output logic            keypad_high_nibble_route,
    output logic            keypad_low_nibble_route,
    output logic            spi_pin_relocate,
    output logic            uart1_pin_relocate,
    output logic            serial1_in_relocate,
    output logic            twowire0_pin_relocate,
    output logic            capture_out_relocate,
    output logic            data_pointer_select,
    output logic      [1:0] ext_irq3_input_select,
    output logic      [1:0] ext_irq2_input_select,
    output logic            timer1_fast_clock,
    output logic            timer0_fast_clock,
    output logic            timer1_clock_out_enable,
    output logic            timer0_clock_out_enable,
    output logic            timer1_count_tick,
    output logic            timer0_count_tick,
    output logic            start_detect_flag,
    output logic            stop_detect_flag,
    output logic            beeper_out,
    output logic            beeper_active,
    output logic            serial0_in_relocate,
    output logic            counter_ext_clock_relocate,
    output logic            twowire1_pin_relocate
);
    import aux_pin_pkg::*;

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0]     clock_out_pin_and_int_polarity;
    logic [7:0]     keypad_spi_uart_pin_routing;
    logic [7:0]     interrupt_input_timer_clock_control;
    logic [7:0]     bus_detect_beeper_pin_routing;
    logic [7:0]     next_cfg0, next_cfg1, next_cfg2, next_cfg3;
    logic           wr0, wr1, wr2, wr3;
    clock_out_sel_t pin60_sel_eff, next_pin60_sel;
    logic           div_phase;
    logic [3:0]     prescale_cnt;
    logic           scl_meta, scl_sync, scl_prev;
    logic           sda_meta, sda_sync, sda_prev;
    logic           osc_meta, osc_sync, osc_prev;
    logic [4:0]     beep_cnt, beep_half;
    logic           start_cond, stop_cond;

    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction : flag_next

    assign wr0 = reg_write && (reg_addr == ADDR_CLOCK_OUT_PIN_AND_INT_POLARITY);
    assign wr1 = reg_write && (reg_addr == ADDR_KEYPAD_SPI_UART_PIN_ROUTING);
    assign wr2 = reg_write && (reg_addr == ADDR_INTERRUPT_INPUT_TIMER_CLOCK);
    assign wr3 = reg_write && (reg_addr == ADDR_BUS_DETECT_BEEPER_PIN_ROUTING);

    assign next_cfg0 = wr0 ? reg_wdata : clock_out_pin_and_int_polarity;
    assign next_cfg1 = wr1 ? reg_wdata : keypad_spi_uart_pin_routing;
    assign next_cfg2 = wr2 ? reg_wdata : interrupt_input_timer_clock_control;

    // ****************************************
    // Bus condition detection
    // ****************************************
    // Pins are foreign to clk; only the second and third stages feed logic
    // Oscillator edges are counted on clk, so it must run well below clk
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            scl_meta <= stw_scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= stw_sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
            osc_meta <= low_freq_rc_osc;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign start_cond = scl_sync && scl_prev && sda_prev && !sda_sync;
    assign stop_cond  = scl_sync && scl_prev && !sda_prev && sda_sync;

    // Flags take only zeros from software; a condition in the clearing cycle wins
    always_comb
    begin
        next_cfg3 = bus_detect_beeper_pin_routing;
        if (wr3)
        begin
            next_cfg3 = reg_wdata;
            next_cfg3[B3_START] = bus_detect_beeper_pin_routing[B3_START];
            next_cfg3[B3_STOP]  = bus_detect_beeper_pin_routing[B3_STOP];
        end
        next_cfg3[B3_START] = flag_next(bus_detect_beeper_pin_routing[B3_START], start_cond,
                                        wr3 && !reg_wdata[B3_START]);
        next_cfg3[B3_STOP]  = flag_next(bus_detect_beeper_pin_routing[B3_STOP], stop_cond,
                                        wr3 && !reg_wdata[B3_STOP]);
    end

    // ****************************************
    // Register update
    // ****************************************
    // same-edge update
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clock_out_pin_and_int_polarity      <= REG_RESET;
            keypad_spi_uart_pin_routing         <= REG_RESET;
            interrupt_input_timer_clock_control <= REG_RESET;
            bus_detect_beeper_pin_routing       <= REG_RESET;
        end
        else
        begin
            clock_out_pin_and_int_polarity      <= next_cfg0;
            keypad_spi_uart_pin_routing         <= next_cfg1;
            interrupt_input_timer_clock_control <= next_cfg2;
            bus_detect_beeper_pin_routing       <= next_cfg3;
        end
    end

    // Unmapped addresses read zero; data valid only the cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= REG_RESET;
        else if (!reg_read)
            reg_rdata <= REG_RESET;
        else
        begin
            unique case (reg_addr)
                ADDR_CLOCK_OUT_PIN_AND_INT_POLARITY: reg_rdata <= clock_out_pin_and_int_polarity;
                ADDR_KEYPAD_SPI_UART_PIN_ROUTING:    reg_rdata <= keypad_spi_uart_pin_routing;
                ADDR_INTERRUPT_INPUT_TIMER_CLOCK:    reg_rdata <= interrupt_input_timer_clock_control;
                ADDR_BUS_DETECT_BEEPER_PIN_ROUTING:  reg_rdata <= bus_detect_beeper_pin_routing;
                default:                             reg_rdata <= REG_RESET;
            endcase
        end
    end

    // ****************************************
    // Routing outputs
    // ****************************************
    // fast drive
    assign pin60_fast_drive           = clock_out_pin_and_int_polarity[B0_FAST_DRV];
    assign port4_pair_function_select = clock_out_pin_and_int_polarity[B0_P4FN_HI:B0_P4FN_LO];
    assign ext_irq1_high_polarity     = clock_out_pin_and_int_polarity[B0_IRQ1_POL];
    assign ext_irq0_high_polarity     = clock_out_pin_and_int_polarity[B0_IRQ0_POL];
    assign keypad_high_nibble_route   = keypad_spi_uart_pin_routing[B1_KEY_HI];
    assign keypad_low_nibble_route    = keypad_spi_uart_pin_routing[B1_KEY_LO];
    assign spi_pin_relocate           = keypad_spi_uart_pin_routing[B1_SPI];
    assign serial1_in_relocate        = keypad_spi_uart_pin_routing[B1_SER1_IN];
    assign capture_out_relocate       = keypad_spi_uart_pin_routing[B1_CAPTURE];
    assign data_pointer_select        = keypad_spi_uart_pin_routing[B1_DATA_POINTER];
    assign ext_irq3_input_select      = interrupt_input_timer_clock_control[B2_IRQ3_HI:B2_IRQ3_LO];
    assign ext_irq2_input_select      = interrupt_input_timer_clock_control[B2_IRQ2_HI:B2_IRQ2_LO];
    assign timer1_fast_clock          = interrupt_input_timer_clock_control[B2_T1_FAST];
    assign timer0_fast_clock          = interrupt_input_timer_clock_control[B2_T0_FAST];
    assign timer1_clock_out_enable    = interrupt_input_timer_clock_control[B2_T1_CKOE];
    assign timer0_clock_out_enable    = interrupt_input_timer_clock_control[B2_T0_CKOE];
    assign start_detect_flag          = bus_detect_beeper_pin_routing[B3_START];
    assign stop_detect_flag           = bus_detect_beeper_pin_routing[B3_STOP];
    assign serial0_in_relocate        = bus_detect_beeper_pin_routing[B3_SER0_IN];
    assign counter_ext_clock_relocate = bus_detect_beeper_pin_routing[B3_ECI];
    assign twowire1_pin_relocate      = bus_detect_beeper_pin_routing[B3_TW1];

    assign next_pin60_sel = sys_clock_internal_rc ? clock_out_sel_t'(next_cfg0[B0_CLKOUT_HI:B0_CLKOUT_LO]) : CLK_OFF;

    // Gated selects are registered from next values so they move with the register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin60_sel_eff         <= CLK_OFF;
            pin60_clock_active    <= 1'b0;
            pin60_clock_pass      <= 1'b0;
            uart1_pin_relocate    <= 1'b0;
            twowire0_pin_relocate <= 1'b0;
        end
        else
        begin
            pin60_sel_eff         <= next_pin60_sel;
            pin60_clock_active    <= (next_pin60_sel != CLK_OFF);
            // undivided clock passes at the pad
            pin60_clock_pass      <= (next_pin60_sel == CLK_DIV1);
            uart1_pin_relocate    <= next_cfg1[B1_UART1] && !next_cfg1[B1_CAPTURE];
            // raw clock field must be 00
            twowire0_pin_relocate <= next_cfg1[B1_TW0] && (next_cfg0[B0_CLKOUT_HI:B0_CLKOUT_LO] == CLK_OFF);
        end
    end

    // ****************************************
    // Pin 6.0 clock divider
    // ****************************************
    // Divide by one cannot come from a flop; the pad takes clk when pass is high
    // master clock dividers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_phase       <= 1'b0;
            pin60_clock_out <= 1'b0;
        end
        else
        begin
            div_phase <= ~div_phase;
            unique case (pin60_sel_eff)
                CLK_DIV2: pin60_clock_out <= ~pin60_clock_out;
                CLK_DIV4: pin60_clock_out <= div_phase ? ~pin60_clock_out : pin60_clock_out;
                CLK_OFF,
                CLK_DIV1: pin60_clock_out <= 1'b0;
            endcase
        end
    end

    // ****************************************
    // Timer prescale ticks
    // ****************************************
    // divide by twelve
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prescale_cnt      <= 4'h0;
            timer0_count_tick <= 1'b0;
            timer1_count_tick <= 1'b0;
        end
        else
        begin
            prescale_cnt      <= (prescale_cnt == PRESCALE_LAST) ? 4'h0 : prescale_cnt + 4'h1;
            timer0_count_tick <= timer0_fast_clock || (prescale_cnt == PRESCALE_LAST);
            timer1_count_tick <= timer1_fast_clock || (prescale_cnt == PRESCALE_LAST);
        end
    end

    // ****************************************
    // Beeper
    // ****************************************
    always_comb
    begin
        unique case (bus_detect_beeper_pin_routing[B3_BEEP_HI:B3_BEEP_LO])
            BEEP_DIV64: beep_half = BEEP_HALF64;
            BEEP_DIV32: beep_half = BEEP_HALF32;
            default:    beep_half = BEEP_HALF16;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            beep_cnt      <= 5'h00;
            beeper_out    <= 1'b0;
            beeper_active <= 1'b0;
        end
        else if (bus_detect_beeper_pin_routing[B3_BEEP_HI:B3_BEEP_LO] == BEEP_OFF)
        begin
            beep_cnt      <= 5'h00;
            beeper_out    <= 1'b0;
            beeper_active <= (next_cfg3[B3_BEEP_HI:B3_BEEP_LO] != BEEP_OFF);
        end
        else
        begin
            beeper_active <= (next_cfg3[B3_BEEP_HI:B3_BEEP_LO] != BEEP_OFF);
            if (osc_sync && !osc_prev)
            begin
                if (beep_cnt >= beep_half)
                begin
                    beep_cnt   <= 5'h00;
                    beeper_out <= ~beeper_out;
                end
                else
                    beep_cnt <= beep_cnt + 5'h01;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rc_clock_gate: assert property (!sys_clock_internal_rc |=> !pin60_clock_active)
        else $error("pin 6.0 clock active without internal RC");
    a_div2_toggle: assert property (pin60_sel_eff == CLK_DIV2 |=> pin60_clock_out != $past(pin60_clock_out))
        else $error("divide-by-two output did not toggle");
    a_clock_off_io: assert property (pin60_sel_eff == CLK_OFF |-> !pin60_clock_pass ##1 !pin60_clock_out)
        else $error("clock output present with field off");
    a_polarity_write: assert property (wr0 |=> ext_irq0_high_polarity == $past(reg_wdata[B0_IRQ0_POL]))
        else $error("interrupt 0 polarity not written");
    a_uart1_capture: assert property (uart1_pin_relocate |-> !capture_out_relocate)
        else $error("secondary UART on port 3 with capture relocated");
    a_twowire0_gate: assert property (twowire0_pin_relocate |-> pin60_sel_eff == CLK_OFF)
        else $error("two-wire 0 relocated while clock field set");
    a_prescale_gap: assert property (timer0_count_tick && !$past(timer0_fast_clock)
        |=> (!timer0_count_tick || $past(timer0_fast_clock))[*8])
        else $error("slow timer tick came too soon");
    a_start_sets: assert property (start_cond |=> start_detect_flag)
        else $error("start condition lost");
    a_stop_sets: assert property (stop_cond |=> stop_detect_flag)
        else $error("stop condition lost");
    a_beeper_off: assert property (bus_detect_beeper_pin_routing[B3_BEEP_HI:B3_BEEP_LO] == BEEP_OFF
        |=> !beeper_out)
        else $error("beeper active with field off");
    a_route_same_edge: assert property (wr1 |=> keypad_spi_uart_pin_routing == $past(reg_wdata))
        else $error("routing register not updated next edge");
    a_read_timing: assert property (reg_read && reg_addr == ADDR_INTERRUPT_INPUT_TIMER_CLOCK && !wr2
        |=> reg_rdata == $past(interrupt_input_timer_clock_control))
        else $error("read data wrong");

    c_start_seen: cover property (start_cond ##1 start_detect_flag);
    c_div4_run: cover property (pin60_sel_eff == CLK_DIV4 && $rose(pin60_clock_out));
    c_beeper_tog: cover property (beeper_active && $rose(beeper_out));
    c_flag_clear: cover property (wr3 && !reg_wdata[B3_STOP] && stop_detect_flag ##1 !stop_detect_flag);

endmodule : aux_pin_function_control

// >>> tb/tb_aux_pin_function_control.sv
// Self-checking bench for the auxiliary pin function control block.
// Assumes aux_pin_pkg and the design module are compiled before it.
`timescale 1ns/1ps

module tb_aux_pin_function_control;
    import aux_pin_pkg::*;
    logic       clk, rst, reg_write, reg_read, sys_clock_internal_rc, stw_scl_in, stw_sda_in, low_freq_rc_osc;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [1:0] port4_pair_function_select, ext_irq3_input_select, ext_irq2_input_select;
    logic       pin60_clock_out, pin60_clock_pass, pin60_clock_active, pin60_fast_drive, ext_irq1_high_polarity,
                ext_irq0_high_polarity, keypad_high_nibble_route, keypad_low_nibble_route, spi_pin_relocate,
                uart1_pin_relocate, serial1_in_relocate, twowire0_pin_relocate, capture_out_relocate,
                data_pointer_select, timer1_fast_clock, timer0_fast_clock, timer1_clock_out_enable,
                timer0_clock_out_enable, timer1_count_tick, timer0_count_tick, start_detect_flag,
                stop_detect_flag, beeper_out, beeper_active, serial0_in_relocate, counter_ext_clock_relocate,
                twowire1_pin_relocate, p;
    int         num_errors = 0, n_compared = 0, cyc = 0, n0, n1;
    logic [7:0] e;

    aux_pin_function_control dut (.*);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Bus tasks and checking
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd

    // Counts level changes of the beeper (sel high) or pin 6.0 clock, sampled after each edge
    task automatic step(input logic sel);
        logic s;
        @(posedge clk);
        #1;
        s = sel ? beeper_out : pin60_clock_out;
        if (s !== p) n0++;
        p = s;
    endtask : step

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Whole run needs about 4050 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            final_report();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        {rst, stw_scl_in, stw_sda_in} = 3'b111;
        {reg_write, reg_read, sys_clock_internal_rc, low_freq_rc_osc} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++)
        begin
            rd(ADDR_CLOCK_OUT_PIN_AND_INT_POLARITY + a[7:0]);
            chk(rv, REG_RESET);
        end
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_CLOCK_OUT_PIN_AND_INT_POLARITY, {2'h0, i[0], 1'b0, i[3:0]});
            chk({3'h0, pin60_fast_drive, port4_pair_function_select, ext_irq1_high_polarity,
                 ext_irq0_high_polarity}, {3'h0, i[0], i[3:0]});
        end
        for (int b = 0; b < 9; b++)
        begin
            e = (b == 8) ? 8'hFF : 8'h01 << b;
            wr(ADDR_KEYPAD_SPI_UART_PIN_ROUTING, e);
            chk({keypad_high_nibble_route, keypad_low_nibble_route, spi_pin_relocate, uart1_pin_relocate,
                 serial1_in_relocate, twowire0_pin_relocate, capture_out_relocate, data_pointer_select},
                (b == 8) ? 8'hEF : e);
        end
        rd(ADDR_KEYPAD_SPI_UART_PIN_ROUTING);
        chk(rv, 8'hFF);
        $display("test routing done");
        wr(ADDR_CLOCK_OUT_PIN_AND_INT_POLARITY, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        chk({5'h0, twowire0_pin_relocate, pin60_clock_active, pin60_clock_pass}, 8'h00);
        @(posedge clk);
        sys_clock_internal_rc <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CLOCK_OUT_PIN_AND_INT_POLARITY, {c[1:0], 6'h00});
            repeat (3) @(posedge clk);
            #1;
            chk({5'h0, twowire0_pin_relocate, pin60_clock_active, pin60_clock_pass},
                {5'h0, c == 0, c != 0, c == 1});
            n0 = 0;
            p = pin60_clock_out;
            repeat (16) step(1'b0);
            chk(n0[7:0], (c == 2) ? 8'h10 : (c == 3) ? 8'h08 : 8'h00);
        end
        $display("test clock out done");
        wr(ADDR_INTERRUPT_INPUT_TIMER_CLOCK, 8'hF7);
        chk({ext_irq3_input_select, ext_irq2_input_select, timer1_fast_clock, timer0_fast_clock,
             timer1_clock_out_enable, timer0_clock_out_enable}, 8'hF7);
        {n0, n1} = 0;
        repeat (24)
        begin
            @(posedge clk);
            #1;
            n0 += timer0_count_tick;
            n1 += timer1_count_tick;
        end
        chk({n0[3:0], n1[3:0]}, 8'h82);
        chk(n0[7:0], 8'h18);
        $display("test timers done");
        @(posedge clk);
        stw_sda_in <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({6'h0, start_detect_flag, stop_detect_flag}, 8'h02);
        @(posedge clk);
        stw_sda_in <= 1'b1;
        repeat (6) @(posedge clk);
        rd(ADDR_BUS_DETECT_BEEPER_PIN_ROUTING);
        chk(rv, 8'hC0);
        wr(ADDR_BUS_DETECT_BEEPER_PIN_ROUTING, 8'hC0);
        chk({6'h0, start_detect_flag, stop_detect_flag}, 8'h03);
        $display("test bus detect done");
        for (int c = 1; c < 4; c++)
        begin
            wr(ADDR_BUS_DETECT_BEEPER_PIN_ROUTING, {2'h0, c[1:0], 4'h7});
            chk({beeper_active, start_detect_flag, stop_detect_flag, serial0_in_relocate,
                 counter_ext_clock_relocate, twowire1_pin_relocate}, 8'h27);
            n0 = 0;
            p = beeper_out;
            repeat (128)
            begin
                repeat (9) step(1'b1);
                @(posedge clk);
                low_freq_rc_osc <= ~low_freq_rc_osc;
            end
            chk({7'h0, n0 + 1 >= (1 << c) && n0 <= (1 << c) + 1}, 8'h01);
        end
        wr(8'hA5, 8'hFF);
        rd(8'hA5);
        chk(rv, 8'h00);
        $display("test beeper and unmapped done");
        final_report();
    end
endmodule : tb_aux_pin_function_control
